// ==== core/memsync_ctrl.sv ====
// Contract
// - misaligned load-reserve or store-conditional word raises an alignment exception
// - reservation kept per 32-byte cache block, not per word
// - sync may go with older ones; younger dispatch stalls until it completes
// - prefetched buffer contents survive sync and issue afterwards unrefetched
// - sync goes to load/store unit and out as a bus barrier
// - sync or load-reserve with record bit set leaves condition field zero undefined
// - store-conditional with record bit clear leaves condition field zero undefined
// - io barrier waits older uncached/write-through ops; younger ones wait for it
// - io barrier issues address-only barrier on the external bus
// - isync waits older completion, discards prefetch, continues sequentially
module memsync_ctrl
  import memsync_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // dispatch
  input  wire logic          op_valid,
  input  wire op_type        op_code,
  input  wire logic          record_bit,
  input  wire logic [AW-1:0] op_addr,
  input  wire logic [AW-1:0] next_pc,
  input  wire logic          older_done,
  input  wire logic          older_io_done,
  // load_store_unit
  input  wire logic          lsu_ready,
  // external bus
  input  wire logic          bus_ack,
  input  wire logic          snoop_wr,
  input  wire logic [AW-1:0] snoop_addr,
  // dispatch control
  output logic               dispatch_stall,
  output logic               op_accept,
  output logic               align_exc,
  // load_store_unit requests
  output logic               load_store_unit_barrier,
  output logic               load_store_unit_store,
  output logic               io_younger_hold,
  // bus barrier
  output logic               bus_req,
  output bar_type            bus_kind,
  // condition field zero
  output logic               cr0_we,
  output logic [3:0]         condition_field_zero,
  // fetch
  output logic               ibuf_flush,
  output logic               fetch_req,
  output logic [AW-1:0]      fetch_addr
);

  state_type state_reg, state_next;
  logic      dispatch_stall_reg, op_accept_reg, align_exc_reg;
  logic      lsu_bar_reg, lsu_st_reg, io_hold_reg, bus_req_reg;
  bar_type   bus_kind_reg;
  logic      cr0_we_reg, flush_reg, fetch_req_reg;
  logic [3:0] cr0_reg;
  logic [AW-1:0] fetch_addr_reg, pc_hold_reg;
  logic      res_hit;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire idle      = (state_reg == ST_IDLE);
  wire take      = op_valid && idle;
  wire is_lr     = take && (op_code == OP_LOADR);
  wire is_sc     = take && (op_code == OP_STCND);
  wire misalign  = (op_addr[WORD_LSB-1:0] != 2'b00);
  wire lr_ok     = is_lr && !misalign;
  wire sc_ok     = is_sc && !misalign;
  wire sc_pass   = sc_ok && res_hit;
  // cr0 eq bit carries pass/fail; invalid forms give an undefined value
  wire sc_valid  = record_bit;
  wire cr_bad    = take && record_bit && (op_code == OP_SYNC || op_code == OP_LOADR);
  wire [3:0] sc_cr = {2'b00, sc_pass, 1'b0};

  reservation_tracker #(.AW(AW)) u_res
  (
    .clk        (clk),
    .arst_n     (arst_n),
    .set_en     (lr_ok),
    .clr_en     (sc_ok),
    .set_addr   (op_addr),
    .check_addr (op_addr),
    .snoop_wr   (snoop_wr),
    .snoop_addr (snoop_addr),
    .held       (),
    .hit        (res_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (take)
        begin
          case (op_code)
            OP_SYNC:  state_next = ST_SYNC_LSU;
            OP_IOBAR: state_next = ST_IO_WAIT;
            OP_ISYNC: state_next = ST_IS_DRAIN;
            default:  state_next = ST_IDLE;
          endcase
        end
      ST_SYNC_LSU: if (lsu_ready) state_next = ST_SYNC_BUS;
      // acknowledge relies on the far cache finishing queued work
      ST_SYNC_BUS: if (bus_ack) state_next = ST_IDLE;
      ST_IO_WAIT:  if (older_io_done && lsu_ready) state_next = ST_IO_BUS;
      ST_IO_BUS:   if (bus_ack) state_next = ST_IDLE;
      ST_IS_DRAIN: if (older_done) state_next = ST_IS_FETCH;
      ST_IS_FETCH: state_next = ST_IDLE;
      default:     state_next = ST_IDLE;
    endcase
  end

  // sync keeps the buffer: no flush on its way back to idle
  wire stall_next = (state_next != ST_IDLE);
  wire lsu_bar_n  = (state_next == ST_SYNC_LSU) || (state_next == ST_IO_WAIT);
  wire bus_n      = (state_next == ST_SYNC_BUS) || (state_next == ST_IO_BUS);
  wire bar_type kind_n = (state_next == ST_SYNC_BUS) ? BAR_SYNC :
                         (state_next == ST_IO_BUS) ? BAR_IO : BAR_NONE;
  wire flush_n    = (state_reg == ST_IS_DRAIN) && older_done;
  // aligned double word of the next sequential instruction
  wire [AW-1:0] dw_addr = {pc_hold_reg[AW-1:DWORD_LSB], 3'b000};
  wire cr_we_n = cr_bad || (is_sc && !misalign);
  wire [3:0] cr_n = (cr_bad || (is_sc && !sc_valid)) ? CR_UNDEF : sc_cr;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg          <= ST_IDLE;
      dispatch_stall_reg <= 1'b0;
      op_accept_reg      <= 1'b0;
      align_exc_reg      <= 1'b0;
      lsu_bar_reg        <= 1'b0;
      lsu_st_reg         <= 1'b0;
      io_hold_reg        <= 1'b0;
      bus_req_reg        <= 1'b0;
      bus_kind_reg       <= BAR_NONE;
      cr0_we_reg         <= 1'b0;
      cr0_reg            <= 4'h0;
      flush_reg          <= 1'b0;
      fetch_req_reg      <= 1'b0;
      fetch_addr_reg     <= '0;
      pc_hold_reg        <= '0;
    end
    else
    begin
      state_reg          <= state_next;
      dispatch_stall_reg <= stall_next;
      op_accept_reg      <= take;
      align_exc_reg      <= (is_lr || is_sc) && misalign;
      lsu_bar_reg        <= lsu_bar_n;
      lsu_st_reg         <= sc_pass && sc_valid;
      io_hold_reg        <= (state_next == ST_IO_WAIT) || (state_next == ST_IO_BUS);
      bus_req_reg        <= bus_n;
      bus_kind_reg       <= kind_n;
      cr0_we_reg         <= cr_we_n;
      cr0_reg            <= cr_n;
      flush_reg          <= flush_n;
      fetch_req_reg      <= flush_n;
      if (flush_n)
        fetch_addr_reg   <= dw_addr;
      if (take && op_code == OP_ISYNC)
        pc_hold_reg      <= next_pc;
    end
  end

  assign dispatch_stall          = dispatch_stall_reg;
  assign op_accept               = op_accept_reg;
  assign align_exc               = align_exc_reg;
  assign load_store_unit_barrier = lsu_bar_reg;
  assign load_store_unit_store   = lsu_st_reg;
  assign io_younger_hold         = io_hold_reg;
  assign bus_req                 = bus_req_reg;
  assign bus_kind                = bus_kind_reg;
  assign cr0_we                  = cr0_we_reg;
  assign condition_field_zero    = cr0_reg;
  assign ibuf_flush              = flush_reg;
  assign fetch_req               = fetch_req_reg;
  assign fetch_addr              = fetch_addr_reg;

endmodule : memsync_ctrl

// ==== core/memsync_pkg.sv ====
package memsync_pkg;

  localparam int ADDR_W = 32;
  // reservation granule: one 32-byte cache block
  localparam int BLOCK_BYTES = 32;
  localparam int BLOCK_LSB = $clog2(BLOCK_BYTES);
  localparam int WORD_LSB = 2;
  localparam int DWORD_LSB = 3;

  // operation codes offered at dispatch
  typedef enum logic [2:0]
  {
    OP_NONE  = 3'b000,
    OP_LOADR = 3'b001,
    OP_STCND = 3'b010,
    OP_SYNC  = 3'b011,
    OP_IOBAR = 3'b100,
    OP_ISYNC = 3'b101
  } op_type;

  // address-only bus barrier kinds
  typedef enum logic [1:0]
  {
    BAR_NONE = 2'b00,
    BAR_SYNC = 2'b01,
    BAR_IO   = 2'b10
  } bar_type;

  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'b000,
    ST_SYNC_LSU = 3'b001,
    ST_SYNC_BUS = 3'b010,
    ST_IO_WAIT  = 3'b011,
    ST_IO_BUS   = 3'b100,
    ST_IS_DRAIN = 3'b101,
    ST_IS_FETCH = 3'b110
  } state_type;

  localparam logic [3:0] CR_UNDEF = 4'h0;

endpackage : memsync_pkg

// ==== core/reservation_tracker.sv ====
module reservation_tracker
  import memsync_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // core side
  input  wire logic          set_en,
  input  wire logic          clr_en,
  input  wire logic [AW-1:0] set_addr,
  input  wire logic [AW-1:0] check_addr,
  // snoop side
  input  wire logic          snoop_wr,
  input  wire logic [AW-1:0] snoop_addr,
  // state
  output logic               held,
  output logic               hit
);

  logic                  valid_reg;
  logic [AW-BLOCK_LSB-1:0] blk_reg;
  wire snoop_hit = snoop_wr && valid_reg && (snoop_addr[AW-1:BLOCK_LSB] == blk_reg);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      valid_reg <= 1'b0;
      blk_reg   <= '0;
    end
    else if (set_en)
    begin
      valid_reg <= 1'b1;
      blk_reg   <= set_addr[AW-1:BLOCK_LSB];
    end
    else if (clr_en || snoop_hit)
      valid_reg <= 1'b0;
  end

  assign held = valid_reg;
  // block compare, not word compare
  assign hit = valid_reg && !snoop_hit && (check_addr[AW-1:BLOCK_LSB] == blk_reg);

endmodule : reservation_tracker

// ==== tb/memsync_bus_model.sv ====
module memsync_bus_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // from the core; lat from the test
  input  wire logic       barrier,
  input  wire logic       bus_req,
  input  wire logic [3:0] lat,
  // answers
  output logic            lsu_ready,
  output logic            bus_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= (bus_req && !bus_ack) ? cnt_reg + 4'h1 : 4'h0;
  // ack only after lat cycles: the queued references drain first
  assign bus_ack   = bus_req && (cnt_reg == lat);
  assign lsu_ready = barrier;
endmodule : memsync_bus_model

// ==== tb/memsync_ctrl_chk.sv ====
module memsync_ctrl_chk
  import memsync_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // clock and reset
  input wire logic          clk,
  input wire logic          arst_n,
  // watched ports
  input wire logic          older_done,
  input wire logic          lsu_ready,
  input wire logic          bus_ack,
  input wire logic          dispatch_stall,
  input wire logic          align_exc,
  input wire logic          load_store_unit_store,
  input wire logic          io_younger_hold,
  input wire logic          bus_req,
  input wire bar_type       bus_kind,
  input wire logic          ibuf_flush,
  input wire logic          fetch_req,
  input wire logic [AW-1:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_bus_stalls: assert property (bus_req |-> dispatch_stall)
    else $error("bus barrier outside stall");
  a_lsu_first: assert property ($rose(bus_req) && bus_kind == BAR_SYNC |-> $past(lsu_ready))
    else $error("sync on bus before load store unit");
  a_req_holds: assert property (bus_req && !bus_ack |=> bus_req)
    else $error("bus barrier dropped early");
  a_ack_ends: assert property (bus_req && bus_ack |=> !bus_req)
    else $error("bus barrier held after ack");
  a_kind_valid: assert property (bus_req |-> bus_kind inside {BAR_SYNC, BAR_IO})
    else $error("bus barrier without kind");
  a_io_holds: assert property (io_younger_hold |-> dispatch_stall)
    else $error("younger hold outside stall");
  a_fetch_dword: assert property (ibuf_flush |-> fetch_req && fetch_addr[2:0] == 3'h0)
    else $error("refetch missing or unaligned");
  a_flush_older: assert property (ibuf_flush |-> $past(older_done))
    else $error("purge before older done");
  a_align_nostore: assert property (align_exc |-> !load_store_unit_store)
    else $error("store on misaligned op");
  cover property (bus_req && bus_kind == BAR_SYNC);
  cover property (bus_req && bus_kind == BAR_IO);
  cover property (ibuf_flush);
endmodule : memsync_ctrl_chk

// ==== tb/test_memsync_ctrl.sv ====
module test_memsync_ctrl
  import memsync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        op_valid, record_bit, older_done, older_io_done, snoop_wr;
  op_type      op_code;
  logic [31:0] op_addr, next_pc, snoop_addr, fetch_addr;
  logic        lsu_ready, bus_ack, dispatch_stall, op_accept, align_exc;
  logic        load_store_unit_barrier, load_store_unit_store, io_younger_hold;
  logic        bus_req, cr0_we, ibuf_flush, fetch_req;
  bar_type     bus_kind;
  logic [3:0]  condition_field_zero, lat;
  int          fails = 0;
  int          n_compared = 0;
  always #5 clk = ~clk;
  memsync_ctrl u_dut
  (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .op_valid                (op_valid),
    .op_code                 (op_code),
    .record_bit              (record_bit),
    .op_addr                 (op_addr),
    .next_pc                 (next_pc),
    .older_done              (older_done),
    .older_io_done           (older_io_done),
    .lsu_ready               (lsu_ready),
    .bus_ack                 (bus_ack),
    .snoop_wr                (snoop_wr),
    .snoop_addr              (snoop_addr),
    .dispatch_stall          (dispatch_stall),
    .op_accept               (op_accept),
    .align_exc               (align_exc),
    .load_store_unit_barrier (load_store_unit_barrier),
    .load_store_unit_store   (load_store_unit_store),
    .io_younger_hold         (io_younger_hold),
    .bus_req                 (bus_req),
    .bus_kind                (bus_kind),
    .cr0_we                  (cr0_we),
    .condition_field_zero    (condition_field_zero),
    .ibuf_flush              (ibuf_flush),
    .fetch_req               (fetch_req),
    .fetch_addr              (fetch_addr)
  );
  memsync_bus_model u_bus (.clk(clk), .arst_n(arst_n), .barrier(load_store_unit_barrier),
    .bus_req(bus_req), .lat(lat), .lsu_ready(lsu_ready), .bus_ack(bus_ack));
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // result packed as align, store, cr0 write, field (masked: it reloads every cycle, written or not)
  // one idle edge first: valid never drops and rises in one time step
  task automatic mem(input op_type c, input logic rb, input logic [31:0] a, input logic [6:0] e);
    @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    record_bit = rb;
    op_addr = a;
    @(negedge clk);
    op_valid = 1'b0;
    chk("accept", 1, op_accept);
    chk("mem", e, {align_exc, load_store_unit_store, cr0_we, condition_field_zero & {4{cr0_we}}});
  endtask : mem
  // a younger load stays offered throughout to probe the dispatch stall
  task automatic barrier(input op_type c, input bar_type k);
    int n, acc, fl, early, hold, lb;
    bar_type seen;
    logic [31:0] fa;
    {n, acc, fl, early, hold, lb} = '0;
    seen = BAR_NONE;
    fa = '0;
    @(negedge clk);
    {older_done, older_io_done} = 2'b00;
    op_valid = 1'b1;
    op_code = c;
    do
    begin
      @(negedge clk);
      op_code = OP_LOADR;
      n++;
      if (n == 3) {older_done, older_io_done} = 2'b11;
      if (bus_req === 1'b1) seen = bus_kind;
      if (ibuf_flush === 1'b1) {fl, fa} = {fl + 1, fetch_addr};
      if (op_accept === 1'b1 && n > 1) acc++;
      if (n < 3 && c != OP_SYNC && (bus_req | ibuf_flush) !== 1'b0) early++;
      if (io_younger_hold === 1'b1) hold++;
      if (load_store_unit_barrier === 1'b1) lb++;
    end while (dispatch_stall === 1'b1 && n < 40);
    op_valid = 1'b0;
    chk("kind", k, seen);
    chk("early", 0, early);
    chk("younger", 0, acc);
    chk("flush", c == OP_ISYNC, fl);
    chk("hold", c == OP_IOBAR, hold != 0);
    chk("lsu", c != OP_ISYNC, lb != 0);
    if (c == OP_ISYNC) chk("fetch", {next_pc[31:3], 3'h0}, fa);
  endtask : barrier
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {op_valid, record_bit, snoop_wr} = 3'h0;
    {older_done, older_io_done} = 2'b11;
    op_code = OP_NONE;
    {op_addr, snoop_addr} = '0;
    next_pc = 32'h0000_1234;
    lat = 4'h0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    mem(OP_LOADR, 1'b0, 32'h0000_0100, 7'h00);
    mem(OP_STCND, 1'b1, 32'h0000_011c, 7'h32);
    mem(OP_STCND, 1'b1, 32'h0000_011c, 7'h10);
    mem(OP_LOADR, 1'b1, 32'h0000_0100, 7'h10);
    mem(OP_STCND, 1'b1, 32'h0000_0101, 7'h40);
    mem(OP_STCND, 1'b1, 32'h0000_0100, 7'h32);
    mem(OP_LOADR, 1'b0, 32'h0000_0102, 7'h40);
    mem(OP_LOADR, 1'b0, 32'h0000_0100, 7'h00);
    mem(OP_STCND, 1'b1, 32'h0000_0120, 7'h10);
    mem(OP_LOADR, 1'b0, 32'h0000_0100, 7'h00);
    {snoop_wr, snoop_addr} = {1'b1, 32'h0000_0104};
    @(negedge clk);
    snoop_wr = 1'b0;
    mem(OP_STCND, 1'b1, 32'h0000_0100, 7'h10);
    mem(OP_LOADR, 1'b0, 32'h0000_0100, 7'h00);
    mem(OP_STCND, 1'b0, 32'h0000_0100, 7'h10);
    barrier(OP_SYNC, BAR_SYNC);
    lat = 4'h3;
    barrier(OP_SYNC, BAR_SYNC);
    barrier(OP_IOBAR, BAR_IO);
    barrier(OP_ISYNC, BAR_NONE);
    end_sim();
  end
  initial
  begin
    #20000;
    fails++;
    end_sim();
  end
endmodule : test_memsync_ctrl
bind memsync_ctrl memsync_ctrl_chk #(.AW(AW)) u_chk
(
  .clk                   (clk),
  .arst_n                (arst_n),
  .older_done            (older_done),
  .lsu_ready             (lsu_ready),
  .bus_ack               (bus_ack),
  .dispatch_stall        (dispatch_stall),
  .align_exc             (align_exc),
  .load_store_unit_store (load_store_unit_store),
  .io_younger_hold       (io_younger_hold),
  .bus_req               (bus_req),
  .bus_kind              (bus_kind),
  .ibuf_flush            (ibuf_flush),
  .fetch_req             (fetch_req),
  .fetch_addr            (fetch_addr)
);
